// [verilog/remote_crit_limit_registers.sv]
// critical limit register group behind an AHB-Lite slave port
`default_nettype none
// How it works
// - low setpoint LSB bits 4:0 unused, always read zero.
// - critical limit is an 8-bit integer resetting to 0x6e, 110 degrees.
// - with override bit cleared, writing a new limit locks the limit.
// - limit format follows the unsigned-format select bit.
// - with select cleared, bit 7 is sign, rest weigh 64 down to 1.
// - critical stays until temperature falls below limit minus hysteresis.
// - hysteresis is 7-bit unsigned in bits 6:0, resets to 0x0a.
// - hysteresis bit 7 accepts any write with no effect.
// - beta bit 1 enables compensation, resets to 1.
// - beta register bits 7:2 always read zero.
// - beta register bit 0 always reads zero.
// - above limit sets critical flag, event and shutdown outputs.
module remote_crit_limit_registers
	import crit_limit_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic CONV_DONE_I,
	input wire logic [7:0] REMOTE_TEMP_I,
	output logic CRIT_SHUTDOWN_O,
	output logic EVENT_O,
	output logic IRQ_O,
	output logic BETA_COMP_EN_O
);
	// =====================================================
	// state
	typedef struct packed {
		logic [2:0] low_lsb;
		logic [7:0] crit_limit;
		logic [6:0] hyst;
		logic beta_en;
		logic override;
		logic unsigned_format_select;
		logic locked;
		logic status;
		logic mask;
		logic irq;
		logic evt;
		logic wr_pend;
		logic [9:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic resp;
	} regs_t;
	regs_t r;
	regs_t r_nxt;
	logic acc_w;
	logic hit_w;
	logic [9:0] addr_w;
	logic crit_w;
	logic rise_w;
	logic rd_w;

	// =====================================================
	// comparator
	crit_eval u_eval (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.conv_done_i(CONV_DONE_I),
		.temp_i(REMOTE_TEMP_I),
		.limit_i(r.crit_limit),
		.hyst_i(r.hyst),
		.usf_i(r.unsigned_format_select),
		.crit_o(crit_w),
		.rise_o(rise_w)
	);

	// =====================================================
	// bus decode
	// only single word transfers are expected; hsize is not checked
	assign acc_w = HSEL_I && HREADY_I && HTRANS_I[1];
	assign addr_w = HADDR_I[9:0];
	assign hit_w = (HADDR_I[31:10] == 22'h0) && (HADDR_I[1:0] == 2'b00);
	assign rd_w = acc_w && !HWRITE_I && hit_w;

	// read mux; reserved and unmapped bits answer zero
	function automatic logic [31:0] rd_mux(input regs_t s, input logic [9:0] a, input logic c);
		logic [31:0] d;
		d = 32'h0;
		case (a)
			A_LOW_LSB: d[7:LOW_LSB_LO] = s.low_lsb;
			A_CRIT_LIMIT: d[7:0] = s.crit_limit;
			A_HYST: d[6:0] = s.hyst;
			A_BETA: d[BETA_EN_BIT] = s.beta_en;
			A_CTRL: begin
				d[OVERRIDE_BIT] = s.override;
				d[USF_BIT] = s.unsigned_format_select;
			end
			A_STATUS: d[CRIT_FLAG_BIT] = s.status;
			A_MASK: d[CRIT_FLAG_BIT] = s.mask;
			A_STATE: begin
				d[LOCK_BIT] = s.locked;
				d[CRIT_ACT_BIT] = c;
			end
			default: d = 32'h0;
		endcase
		return d;
	endfunction

	// =====================================================
	// next state
	always_comb begin
		r_nxt = r;
		r_nxt.ready = 1'b1;
		r_nxt.resp = 1'b0;
		r_nxt.wr_pend = acc_w && HWRITE_I && hit_w;
		r_nxt.wr_addr = addr_w;
		// data phase of a write: store the word
		if (r.wr_pend) begin
			case (r.wr_addr)
				A_LOW_LSB: r_nxt.low_lsb = HWDATA_I[7:LOW_LSB_LO];
				A_CRIT_LIMIT: begin
					if (!r.locked) begin
						r_nxt.crit_limit = HWDATA_I[7:0];
						r_nxt.locked = !r.override;
					end
				end
				A_HYST: r_nxt.hyst = HWDATA_I[6:0];
				A_BETA: r_nxt.beta_en = HWDATA_I[BETA_EN_BIT];
				A_CTRL: begin
					r_nxt.override = HWDATA_I[OVERRIDE_BIT];
					r_nxt.unsigned_format_select = HWDATA_I[USF_BIT];
				end
				A_MASK: r_nxt.mask = HWDATA_I[CRIT_FLAG_BIT];
				default: r_nxt.resp = 1'b0;
			endcase
		end
		// address phase of a read: capture data, a status read clears it
		r_nxt.rdata = 32'h0;
		if (acc_w && !HWRITE_I && hit_w) begin
			r_nxt.rdata = rd_mux(r, addr_w, crit_w);
			if (addr_w == A_STATUS) begin
				r_nxt.status = 1'b0;
			end
		end
		// a new event beats a clear in the same cycle
		if (rise_w) begin
			r_nxt.status = 1'b1;
		end
		r_nxt.evt = r_nxt.status;
		r_nxt.irq = r_nxt.status && !r_nxt.mask;
	end

	// register the whole state
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			r <= '0;
			r.low_lsb <= RST_LOW_LSB;
			r.crit_limit <= RST_CRIT_LIMIT;
			r.hyst <= RST_HYST;
			r.beta_en <= RST_BETA_EN;
			r.override <= RST_OVERRIDE;
			r.unsigned_format_select <= RST_USF;
			r.mask <= RST_MASK;
			r.ready <= 1'b1;
		end else begin
			r <= r_nxt;
		end
	end

	// =====================================================
	// outputs, all from flops
	assign HRDATA_O = r.rdata;
	assign HREADYOUT_O = r.ready;
	assign HRESP_O = r.resp;
	assign CRIT_SHUTDOWN_O = crit_w;
	assign EVENT_O = r.evt;
	assign IRQ_O = r.irq;
	assign BETA_COMP_EN_O = r.beta_en;

	// =====================================================
	// checks
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	low_lsb_zero_a: assert property (acc_w && !HWRITE_I && hit_w && addr_w == A_LOW_LSB |=> HRDATA_O[4:0] == 5'h0)
		else $error("low setpoint reserved bits not zero");
	limit_reset_a: assert property ($rose(RST_N_I) |-> r.crit_limit == 8'h6e)
		else $error("critical limit reset value wrong");
	limit_lock_a: assert property (r.locked |=> $stable(r.crit_limit) && r.locked)
		else $error("locked critical limit changed");
	lock_arm_a: assert property (r.wr_pend && r.wr_addr == A_CRIT_LIMIT && !r.locked && !r.override |=> r.locked)
		else $error("limit write with override cleared did not lock");
	hyst_field_a: assert property (r.wr_pend && r.wr_addr == A_HYST |=> r.hyst == $past(HWDATA_I[6:0]))
		else $error("hysteresis field not stored");
	hyst_read_a: assert property (acc_w && !HWRITE_I && hit_w && addr_w == A_HYST |=> !HRDATA_O[7])
		else $error("hysteresis spare bit read back");
	beta_out_a: assert property (BETA_COMP_EN_O == r.beta_en)
		else $error("beta enable output differs from register");
	beta_zero_a: assert property (acc_w && !HWRITE_I && addr_w == A_BETA |=> HRDATA_O[7:2] == 6'h0 && !HRDATA_O[0])
		else $error("beta reserved bits not zero");
	flag_set_a: assert property (rise_w |=> EVENT_O && r.status && CRIT_SHUTDOWN_O)
		else $error("critical event not flagged");

	// =====================================================
	// bus handshake checks
	// zero wait states: the master never stalls on this slave

	// ready stays high in every cycle
	ready_high_a: assert property (HREADYOUT_O)
		else $error("ready dropped");

	// every answer is okay
	resp_okay_a: assert property (!HRESP_O)
		else $error("error response seen");

	// read data only stand in a read data phase
	rdata_idle_a: assert property (!rd_w |=> HRDATA_O == 32'h0)
		else $error("read data outside a read");

	// registers are one byte wide
	rdata_upper_a: assert property (HRDATA_O[31:8] == 24'h0)
		else $error("upper read bits not zero");

	// a write address phase never loads read data
	wr_no_rdata_a: assert property (acc_w && HWRITE_I |=> HRDATA_O == 32'h0)
		else $error("write produced read data");

	// unmapped reads answer zero
	unmapped_rd_a: assert property (acc_w && !HWRITE_I && !hit_w |=> HRDATA_O == 32'h0)
		else $error("unmapped read not zero");

	// a mapped write arms its data phase
	pend_set_a: assert property (acc_w && HWRITE_I && hit_w |=> r.wr_pend)
		else $error("write data phase not armed");

	// without a write no data phase is pending
	pend_clear_a: assert property (!(acc_w && HWRITE_I) |=> !r.wr_pend)
		else $error("stray write data phase");

	// =====================================================
	// register read-back checks
	// each read returns the value held at its address edge

	// low setpoint field reads back
	low_rd_val_a: assert property (rd_w && addr_w == A_LOW_LSB |=> HRDATA_O[7:5] == $past(r.low_lsb))
		else $error("low setpoint read wrong");

	// limit reads back
	crit_rd_val_a: assert property (rd_w && addr_w == A_CRIT_LIMIT |=> HRDATA_O[7:0] == $past(r.crit_limit))
		else $error("critical limit read wrong");

	// hysteresis reads back
	hyst_rd_val_a: assert property (rd_w && addr_w == A_HYST |=> HRDATA_O[6:0] == $past(r.hyst))
		else $error("hysteresis read wrong");

	// beta enable reads back
	beta_rd_val_a: assert property (rd_w && addr_w == A_BETA |=> HRDATA_O[1] == $past(r.beta_en))
		else $error("beta enable read wrong");

	// control bits read back
	ctrl_rd_val_a: assert property (rd_w && addr_w == A_CTRL |=> HRDATA_O[1:0] == $past({r.override, r.unsigned_format_select}))
		else $error("control read wrong");

	// status bit reads back before its clear
	status_rd_val_a: assert property (rd_w && addr_w == A_STATUS |=> HRDATA_O[0] == $past(r.status))
		else $error("status read wrong");

	// mask bit reads back
	mask_rd_val_a: assert property (rd_w && addr_w == A_MASK |=> HRDATA_O[0] == $past(r.mask))
		else $error("mask read wrong");

	// lock and critical state read back
	state_rd_val_a: assert property (rd_w && addr_w == A_STATE |=> HRDATA_O[1:0] == $past({crit_w, r.locked}))
		else $error("state read wrong");

	// =====================================================
	// register write checks
	// fields change only in the data phase of their own write

	// low setpoint field stores its bits
	low_store_a: assert property (r.wr_pend && r.wr_addr == A_LOW_LSB |=> r.low_lsb == $past(HWDATA_I[7:5]))
		else $error("low setpoint not stored");

	// an unlocked limit write stores the value
	limit_store_a: assert property (r.wr_pend && r.wr_addr == A_CRIT_LIMIT && !r.locked |=> r.crit_limit == $past(HWDATA_I[7:0]))
		else $error("critical limit not stored");

	// the limit moves only by its own write
	limit_hold_a: assert property (!(r.wr_pend && r.wr_addr == A_CRIT_LIMIT) |=> $stable(r.crit_limit))
		else $error("critical limit changed unasked");

	// hysteresis moves only by its own write
	hyst_hold_a: assert property (!(r.wr_pend && r.wr_addr == A_HYST) |=> $stable(r.hyst))
		else $error("hysteresis changed unasked");

	// beta enable stores its bit
	beta_store_a: assert property (r.wr_pend && r.wr_addr == A_BETA |=> r.beta_en == $past(HWDATA_I[1]))
		else $error("beta enable not stored");

	// beta output moves only by its own write
	beta_hold_a: assert property (!(r.wr_pend && r.wr_addr == A_BETA) |=> $stable(BETA_COMP_EN_O))
		else $error("beta enable changed unasked");

	// override bit stores its value
	override_store_a: assert property (r.wr_pend && r.wr_addr == A_CTRL |=> r.override == $past(HWDATA_I[1]))
		else $error("override not stored");

	// format select stores its value
	usf_store_a: assert property (r.wr_pend && r.wr_addr == A_CTRL |=> r.unsigned_format_select == $past(HWDATA_I[0]))
		else $error("format select not stored");

	// with override set a limit write leaves it unlocked
	lock_free_a: assert property (r.wr_pend && r.wr_addr == A_CRIT_LIMIT && !r.locked && r.override |=> !r.locked)
		else $error("limit locked with override set");

	// only a limit write can lock
	lock_only_a: assert property (!r.locked && !(r.wr_pend && r.wr_addr == A_CRIT_LIMIT) |=> !r.locked)
		else $error("limit locked without a write");

	// mask stores its bit
	mask_store_a: assert property (r.wr_pend && r.wr_addr == A_MASK |=> r.mask == $past(HWDATA_I[0]))
		else $error("mask not stored");

	// =====================================================
	// status and interrupt checks
	// set beats clear, so an event at a read is never lost

	// a status read with no event clears the bit
	status_clear_a: assert property (rd_w && addr_w == A_STATUS && !rise_w |=> !r.status)
		else $error("status not cleared by read");

	// an event always sets the bit
	status_set_a: assert property (rise_w |=> r.status)
		else $error("status not set by event");

	// status stays until read
	status_keep_a: assert property (r.status && !(rd_w && addr_w == A_STATUS) |=> r.status)
		else $error("status lost without read");

	// status never sets without an event
	status_idle_a: assert property (!r.status && !rise_w |=> !r.status)
		else $error("status set without event");

	// event output mirrors the status bit
	event_mirror_a: assert property (EVENT_O == r.status)
		else $error("event output differs from status");

	// interrupt is the unmasked status
	irq_level_a: assert property (IRQ_O == (r.status && !r.mask))
		else $error("interrupt level wrong");
endmodule
`default_nettype wire

// [verilog/crit_limit_pkg.sv]
// shared offsets, field positions and reset values of the critical limit register group
`default_nettype none
package crit_limit_pkg;
	// =====================================================
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_LOW_LSB = 8'h14;
	localparam logic [7:0] IDX_CRIT_LIMIT = 8'h19;
	localparam logic [7:0] IDX_HYST = 8'h21;
	localparam logic [7:0] IDX_BETA = 8'h30;
	localparam logic [7:0] IDX_CTRL = 8'h40;
	localparam logic [7:0] IDX_STATUS = 8'h41;
	localparam logic [7:0] IDX_MASK = 8'h42;
	localparam logic [7:0] IDX_STATE = 8'h43;
	localparam logic [9:0] A_LOW_LSB = {IDX_LOW_LSB, 2'b00};
	localparam logic [9:0] A_CRIT_LIMIT = {IDX_CRIT_LIMIT, 2'b00};
	localparam logic [9:0] A_HYST = {IDX_HYST, 2'b00};
	localparam logic [9:0] A_BETA = {IDX_BETA, 2'b00};
	localparam logic [9:0] A_CTRL = {IDX_CTRL, 2'b00};
	localparam logic [9:0] A_STATUS = {IDX_STATUS, 2'b00};
	localparam logic [9:0] A_MASK = {IDX_MASK, 2'b00};
	localparam logic [9:0] A_STATE = {IDX_STATE, 2'b00};
	// =====================================================
	// field positions
	localparam int LOW_LSB_LO = 5;
	localparam int BETA_EN_BIT = 1;
	localparam int OVERRIDE_BIT = 1;
	localparam int USF_BIT = 0;
	localparam int CRIT_FLAG_BIT = 0;
	localparam int LOCK_BIT = 0;
	localparam int CRIT_ACT_BIT = 1;
	// =====================================================
	// reset values
	localparam logic [2:0] RST_LOW_LSB = 3'h0;
	localparam logic [7:0] RST_CRIT_LIMIT = 8'h6e;
	localparam logic [6:0] RST_HYST = 7'h0a;
	localparam logic RST_BETA_EN = 1'b1;
	localparam logic RST_OVERRIDE = 1'b1;
	localparam logic RST_USF = 1'b0;
	localparam logic RST_MASK = 1'b0;
endpackage
`default_nettype wire

// [verilog/crit_eval.sv]
// critical temperature comparator with hysteresis, evaluated per finished conversion
`default_nettype none
module crit_eval
	import crit_limit_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic conv_done_i,
	input wire logic [7:0] temp_i,
	input wire logic [7:0] limit_i,
	input wire logic [6:0] hyst_i,
	input wire logic usf_i,
	output logic crit_o,
	output logic rise_o
);
	// =====================================================
	// state
	typedef struct packed {
		logic crit;
		logic rise;
	} eval_t;
	eval_t s_r;
	eval_t s_nxt;
	logic signed [9:0] t_w;
	logic signed [9:0] l_w;
	logic signed [9:0] rel_w;

	// both operands widened the same way, so signed and unsigned forms compare alike
	function automatic logic signed [9:0] widen(input logic [7:0] v, input logic u);
		return u ? $signed({2'b00, v}) : $signed({{2{v[7]}}, v});
	endfunction

	// limit minus hysteresis cannot wrap in ten bits
	assign t_w = widen(temp_i, usf_i);
	assign l_w = widen(limit_i, usf_i);
	assign rel_w = l_w - $signed({3'b000, hyst_i});

	// set above the limit, release only below limit minus hysteresis
	always_comb begin
		s_nxt = s_r;
		s_nxt.rise = 1'b0;
		if (conv_done_i) begin
			if (!s_r.crit && t_w > l_w) begin
				s_nxt.crit = 1'b1;
				s_nxt.rise = 1'b1;
			end else if (s_r.crit && t_w < rel_w) begin
				s_nxt.crit = 1'b0;
			end
		end
	end

	// register the whole state
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign crit_o = s_r.crit;
	assign rise_o = s_r.rise;

	// =====================================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	crit_set_a: assert property (conv_done_i && !crit_o && t_w > l_w |=> crit_o && rise_o)
		else $error("critical not raised above limit");
	crit_hold_a: assert property (crit_o && !(conv_done_i && t_w < rel_w) |=> crit_o)
		else $error("critical released above release point");
	sign_fmt_a: assert property (conv_done_i && !usf_i && temp_i[7] && !limit_i[7] && !crit_o |=> !crit_o)
		else $error("negative reading tripped positive limit");
	eval_gate_a: assert property (!conv_done_i |=> $stable(crit_o))
		else $error("critical changed without a conversion");
endmodule
`default_nettype wire

// [tb/remote_crit_limit_registers_bench.sv]
// self-checking bench for the critical limit register group
`default_nettype none
module remote_crit_limit_registers_bench
	import crit_limit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// signals
	logic CLK_I, RST_N_I, HSEL_I, HWRITE_I, CONV_DONE_I;
	logic [31:0] HADDR_I, HWDATA_I, HRDATA_O, rd_s, d;
	logic [1:0] HTRANS_I;
	logic [7:0] REMOTE_TEMP_I;
	logic HREADYOUT_O, HRESP_O, CRIT_SHUTDOWN_O, EVENT_O, IRQ_O, BETA_COMP_EN_O, rdy_s;
	int miscompares = 0;
	int checked = 0;
	int cycles = 0;
	remote_crit_limit_registers dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I),
		.HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2),
		.HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
		.HRESP_O(HRESP_O), .CONV_DONE_I(CONV_DONE_I), .REMOTE_TEMP_I(REMOTE_TEMP_I),
		.CRIT_SHUTDOWN_O(CRIT_SHUTDOWN_O), .EVENT_O(EVENT_O), .IRQ_O(IRQ_O), .BETA_COMP_EN_O(BETA_COMP_EN_O));
	// =====================================================
	// clock, settled copies of bus outputs, hang guard
	initial begin
		CLK_I = 1'b0;
		forever #2 CLK_I = ~CLK_I;
	end
	// bus outputs move at the rising edge, so the falling edge gives a race-free copy
	always @(negedge CLK_I) begin
		rdy_s = HREADYOUT_O;
		rd_s = HRDATA_O;
	end
	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == 4000) begin
			miscompares++;
			finish_test();
		end
	end
	// =====================================================
	// shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single AHB transfer; the answer is awaited, never assumed
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd, output logic [31:0] rd);
		@(posedge CLK_I);
		HSEL_I <= 1'b1;
		HTRANS_I <= 2'b10;
		HWRITE_I <= wr;
		HADDR_I <= {22'h0, a};
		do @(posedge CLK_I); while (rdy_s !== 1'b1);
		HSEL_I <= 1'b0;
		HTRANS_I <= 2'b00;
		HWDATA_I <= {24'h0, wd};
		do @(posedge CLK_I); while (rdy_s !== 1'b1);
		rd = rd_s;
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		bus(1'b1, a, v, d);
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] exp);
		bus(1'b0, a, 8'h00, d);
		chk(d, {24'h0, exp});
	endtask
	// one conversion, then the shutdown, event and interrupt levels are judged
	task automatic conv(input logic [7:0] t, input logic [2:0] exp);
		@(posedge CLK_I);
		CONV_DONE_I <= 1'b1;
		REMOTE_TEMP_I <= t;
		@(posedge CLK_I);
		CONV_DONE_I <= 1'b0;
		@(posedge CLK_I);
		@(negedge CLK_I);
		chk({29'h0, CRIT_SHUTDOWN_O, EVENT_O, IRQ_O}, {29'h0, exp});
	endtask
	// =====================================================
	// scenarios
	task automatic t_reset();
		rdchk(A_LOW_LSB, 8'h00);
		rdchk(A_CRIT_LIMIT, 8'h6e);
		rdchk(A_HYST, 8'h0a);
		rdchk(A_BETA, 8'h02);
		chk({31'h0, BETA_COMP_EN_O}, 32'h1);
		chk({31'h0, HRESP_O}, 32'h0);
		$display("reset values done");
	endtask
	task automatic t_fields();
		wr(A_LOW_LSB, 8'hff);
		rdchk(A_LOW_LSB, 8'he0);
		wr(A_BETA, 8'hfd);
		rdchk(A_BETA, 8'h00);
		chk({31'h0, BETA_COMP_EN_O}, 32'h0);
		wr(A_BETA, 8'hff);
		rdchk(A_BETA, 8'h02);
		chk({31'h0, BETA_COMP_EN_O}, 32'h1);
		wr(10'h3fc, 8'hff);
		rdchk(10'h3fc, 8'h00);
		$display("field access done");
	endtask
	task automatic critical_temperature();
		wr(A_HYST, 8'h85);
		rdchk(A_HYST, 8'h05);
		wr(A_CRIT_LIMIT, 8'h50);
		conv(8'h50, 3'b000);
		conv(8'h51, 3'b111);
		rdchk(A_STATUS, 8'h01);
		conv(8'h4b, 3'b100);
		conv(8'h4a, 3'b000);
		wr(A_HYST, 8'h00);
		conv(8'h51, 3'b111);
		conv(8'h4f, 3'b011);
		wr(A_MASK, 8'h01);
		conv(8'h00, 3'b010);
		conv(8'h51, 3'b110);
		rdchk(A_STATUS, 8'h01);
		rdchk(A_STATUS, 8'h00);
		wr(A_MASK, 8'h00);
		conv(8'h00, 3'b000);
		$display("critical hysteresis done");
	endtask
	task automatic t_format();
		conv(8'h90, 3'b000);
		wr(A_CTRL, 8'h03);
		conv(8'h90, 3'b111);
		rdchk(A_STATUS, 8'h01);
		conv(8'h00, 3'b000);
		wr(A_CTRL, 8'h02);
		$display("limit format done");
	endtask
	task automatic t_lock();
		wr(A_CRIT_LIMIT, 8'h30);
		rdchk(A_STATE, 8'h00);
		wr(A_CTRL, 8'h00);
		wr(A_CRIT_LIMIT, 8'h40);
		rdchk(A_STATE, 8'h01);
		wr(A_CRIT_LIMIT, 8'h20);
		rdchk(A_CRIT_LIMIT, 8'h40);
		wr(A_CTRL, 8'h02);
		wr(A_CRIT_LIMIT, 8'h20);
		rdchk(A_CRIT_LIMIT, 8'h40);
		conv(8'h41, 3'b111);
		$display("limit lock done");
	endtask
	// =====================================================
	// closing report
	task automatic finish_test();
		$display("compares %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// =====================================================
	// main sequence
	initial begin
		RST_N_I = 1'b0;
		HSEL_I = 1'b0;
		HTRANS_I = 2'b00;
		HWRITE_I = 1'b0;
		HADDR_I = 32'h0;
		HWDATA_I = 32'h0;
		CONV_DONE_I = 1'b0;
		REMOTE_TEMP_I = 8'h00;
		repeat (10) @(posedge CLK_I);
		RST_N_I <= 1'b1;
		t_reset();
		t_fields();
		critical_temperature();
		t_format();
		t_lock();
		finish_test();
	end
endmodule
`default_nettype wire
